/* File: design/dcc_map.vh */
// Purpose: register map and constants of the dual comparator control block
// Assumes: 8-bit registers on classic wishbone, byte addresses
// Notes: included by the channel and top modules
// Summary of operation
// [RULE_01] bit 0 switches channel on, resets off
// [RULE_02] bit 1 reads comparator output, resets zero
// [RULE_03] result holds last value while channel off
// [RULE_04] software waits 100 us before reading result
// [RULE_05] mode bits: off, fall, rise, both
// [RULE_06] selected edge raises channel interrupt request
// [RULE_07] edges follow result with same polarity
// [RULE_08] bit 2 picks direct or 16k sampled detection
// [RULE_09] no sampling while in stop mode
// [RULE_10] registers at F950/F951 and F954/F955, reset 00
// [RULE_11] software sets mode before switching channel on
// [RULE_12] two identical independent channels 0 and 1
// [RULE_13] synchronise output; sampled edge needs differing samples
`ifndef DCC_MAP_VH
`define DCC_MAP_VH
`define DCC_ADDR_W 16
`define DCC_CH0_CTRL 16'hF950
`define DCC_CH0_MODE 16'hF951
`define DCC_CH1_CTRL 16'hF954
`define DCC_CH1_MODE 16'hF955
`define DCC_IRQ_STAT 16'hF958
`define DCC_IRQ_MASK 16'hF959
`define DCC_REG_RESET 8'h00
`define DCC_BIT_ON 0
`define DCC_BIT_RESULT 1
`define DCC_BIT_SAMPLED 2
`define DCC_MODE_OFF 2'h0
`define DCC_MODE_FALL 2'h1
`define DCC_MODE_RISE 2'h2
`define DCC_MODE_BOTH 2'h3
`define DCC_SETTLE_NS 100000
`define DCC_CLK_NS 100
`endif

/* File: design/dcc_channel.v */
// Purpose: one comparator channel: result latch and edge detection
// Assumes: compare_out is asynchronous, slow_tick is a one-cycle pulse
// Notes: edge_o pulses one cycle per detected edge
`timescale 1ns/10ps
`include "dcc_map.vh"
module dcc_channel (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire on_i,
    input wire [1:0] mode_i,
    input wire sampled_i,
    input wire tick_i,
    input wire stop_i,
    input wire compare_out_i,
    output reg result_o,
    output wire edge_o
);
    reg sync1_reg;
    reg sync2_reg;
    reg prev_reg;
    reg samp_reg;
    reg samp_prev_reg;
    wire rise;
    wire fall;
    wire sample_now;

    assign sample_now = tick_i && !stop_i; // RULE_09
    // sampled path compares two consecutive samples only
    assign rise = sampled_i ? (samp_reg && !samp_prev_reg && sample_now)
        : (sync2_reg && !prev_reg); // RULE_08 RULE_13
    assign fall = sampled_i ? (!samp_reg && samp_prev_reg && sample_now)
        : (!sync2_reg && prev_reg); // RULE_08 RULE_13
    // samp_reg holds the newest sample; edge seen on the tick after
    assign edge_o = on_i && (((mode_i == `DCC_MODE_RISE ||
        mode_i == `DCC_MODE_BOTH) && rise) ||
        ((mode_i == `DCC_MODE_FALL || mode_i == `DCC_MODE_BOTH) && fall));
        // RULE_05 RULE_06 RULE_07

    always @(posedge clk_i) begin
        if (rst_i) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            prev_reg <= 1'b0;
            samp_reg <= 1'b0;
            samp_prev_reg <= 1'b0;
            result_o <= 1'b0; // RULE_02
        end else if (ce_i) begin
            sync1_reg <= compare_out_i; // RULE_13
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
            if (sample_now) begin
                samp_reg <= sync2_reg;
                samp_prev_reg <= samp_reg;
            end
            if (on_i)
                result_o <= sync2_reg; // RULE_02 RULE_07
            // off: result holds last comparison RULE_03
        end
    end
endmodule // dcc_channel

/* File: design/dcc_top.v */
// Purpose: dual comparator control with wishbone registers and irq
// Assumes: classic wishbone, 8-bit data, one clock at 10 MHz
// Notes: settle wait before reading result is left to software
//
// The Wishbone register port is this design's own decision.
`timescale 1ns/10ps
`include "dcc_map.vh"
module dcc_top #(
    parameter CHANNELS = 2
) (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [15:0] wb_adr_i,
    input wire [0:0] wb_sel_i,
    input wire [7:0] wb_dat_i,
    output reg [7:0] wb_dat_o,
    output reg wb_ack_o,
    output wire wb_err_o,
    input wire stop_mode_i,
    input wire slow_tick_16k_i,
    input wire channel0_compare_out_i,
    input wire channel1_compare_out_i,
    output wire channel0_on_o,
    output wire channel1_on_o,
    output wire [1:0] channel_irq_o,
    output wire irq_o
);
    // minimum cycles software should wait after switching on
    localparam SETTLE_CYC = `DCC_SETTLE_NS / `DCC_CLK_NS; // RULE_04

    reg [1:0] on_reg;
    reg [1:0] mode0_reg;
    reg [1:0] mode1_reg;
    reg [1:0] samp_reg;
    reg [1:0] stat_reg;
    reg [1:0] mask_reg;
    reg [1:0] stat_next;
    reg [7:0] rd_next;
    wire [1:0] result;
    wire [1:0] edge_ev;
    wire req;
    wire wr;
    wire wsel;

    assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wsel = wb_sel_i[0];
    assign wr = req && wb_we_i && wsel;
    assign wb_err_o = 1'b0;

    dcc_channel u_ch0 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .on_i(on_reg[0]),
        .mode_i(mode0_reg),
        .sampled_i(samp_reg[0]),
        .tick_i(slow_tick_16k_i),
        .stop_i(stop_mode_i),
        .compare_out_i(channel0_compare_out_i),
        .result_o(result[0]),
        .edge_o(edge_ev[0])
    ); // RULE_12
    dcc_channel u_ch1 (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .on_i(on_reg[1]),
        .mode_i(mode1_reg),
        .sampled_i(samp_reg[1]),
        .tick_i(slow_tick_16k_i),
        .stop_i(stop_mode_i),
        .compare_out_i(channel1_compare_out_i),
        .result_o(result[1]),
        .edge_o(edge_ev[1])
    ); // RULE_12

    assign channel0_on_o = on_reg[0];
    assign channel1_on_o = on_reg[1];
    assign channel_irq_o = edge_ev & {2{ce_i}}; // RULE_06
    assign irq_o = |(stat_reg & mask_reg);

    always @* begin
        rd_next = `DCC_REG_RESET;
        if (wb_adr_i == `DCC_CH0_CTRL) begin
            rd_next = {6'h00, result[0], on_reg[0]}; // RULE_02
        end else if (wb_adr_i == `DCC_CH0_MODE) begin
            rd_next = {5'h00, samp_reg[0], mode0_reg};
        end else if (wb_adr_i == `DCC_CH1_CTRL) begin
            rd_next = {6'h00, result[1], on_reg[1]};
        end else if (wb_adr_i == `DCC_CH1_MODE) begin
            rd_next = {5'h00, samp_reg[1], mode1_reg};
        end else if (wb_adr_i == `DCC_IRQ_STAT) begin
            rd_next = {6'h00, stat_reg};
        end else if (wb_adr_i == `DCC_IRQ_MASK) begin
            rd_next = {6'h00, mask_reg};
        end
    end

    always @* begin
        stat_next = stat_reg;
        if (wr && wb_adr_i == `DCC_IRQ_STAT)
            stat_next = stat_next & ~wb_dat_i[1:0];
        // a new event beats a clear in the same cycle
        stat_next = stat_next | edge_ev;
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            on_reg <= 2'h0; // RULE_01 RULE_10
            mode0_reg <= `DCC_MODE_OFF; // RULE_05
            mode1_reg <= `DCC_MODE_OFF;
            samp_reg <= 2'h0; // RULE_08
            stat_reg <= 2'h0;
            mask_reg <= 2'h0;
            wb_ack_o <= 1'b0;
            wb_dat_o <= `DCC_REG_RESET;
        end else if (ce_i) begin
            stat_reg <= stat_next;
            wb_ack_o <= req;
            if (req)
                wb_dat_o <= rd_next;
            if (wr) begin
                if (wb_adr_i == `DCC_CH0_CTRL) begin
                    on_reg[0] <= wb_dat_i[`DCC_BIT_ON]; // RULE_01 RULE_10
                end else if (wb_adr_i == `DCC_CH0_MODE) begin
                    mode0_reg <= wb_dat_i[1:0]; // RULE_05
                    samp_reg[0] <= wb_dat_i[`DCC_BIT_SAMPLED]; // RULE_08
                end else if (wb_adr_i == `DCC_CH1_CTRL) begin
                    on_reg[1] <= wb_dat_i[`DCC_BIT_ON];
                end else if (wb_adr_i == `DCC_CH1_MODE) begin
                    mode1_reg <= wb_dat_i[1:0];
                    samp_reg[1] <= wb_dat_i[`DCC_BIT_SAMPLED];
                end else if (wb_adr_i == `DCC_IRQ_MASK) begin
                    mask_reg <= wb_dat_i[1:0];
                end
            end
        end
    end
endmodule // dcc_top

/* File: tb/dcc_checker.sv */
// Purpose: port assertions for dcc_top
// Assumes: one clock, sync reset
// Notes: sel is not watched, bench holds it high
`timescale 1ns/10ps
`include "dcc_map.vh"
module dcc_checker (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [15:0] wb_adr_i,
    input wire [7:0] wb_dat_i,
    input wire wb_ack_o,
    input wire channel0_on_o,
    input wire channel1_on_o,
    input wire [1:0] channel_irq_o,
    input wire irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    endsequence
    sequence s_wr;
        s_req ##0 wb_we_i;
    endsequence
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_ack_prompt: assert property (s_req |=> wb_ack_o)
        else $error("request not acked next cycle");
    a_ack_caused: assert property ($rose(wb_ack_o) |->
        $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
    a_on0_write: assert property (s_wr ##0 wb_adr_i == `DCC_CH0_CTRL
        |=> channel0_on_o == $past(wb_dat_i[0])) else $error("ch0 on");
    a_on1_write: assert property (s_wr ##0 wb_adr_i == `DCC_CH1_CTRL
        |=> channel1_on_o == $past(wb_dat_i[0])) else $error("ch1 on");
    a_on_quiet: assert property (!(wb_cyc_i && wb_stb_i && wb_we_i)
        |=> $stable({channel0_on_o, channel1_on_o})) else $error("on moved");
    a_irq_when_on: assert property (channel_irq_o[0] |->
        channel0_on_o || $past(channel0_on_o)) else $error("irq while off");
    a_irq_source: assert property ($rose(irq_o) |->
        $past(|channel_irq_o) || wb_ack_o) else $error("irq without event");
endmodule // dcc_checker
bind dcc_top dcc_checker i_dcc_checker (.clk_i, .rst_i, .ce_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_ack_o, .channel0_on_o,
    .channel1_on_o, .channel_irq_o, .irq_o);

/* File: tb/dcc_analog_model.sv */
// Purpose: behavioural comparator core for one channel
// Assumes: lvl_i is the sign of plus minus input
// Notes: settling is not modelled, bench waits anyway
`timescale 1ns/10ps
module dcc_analog_model (
    input wire clk_i,
    input wire on_i,
    input wire lvl_i,
    output reg out_o
);
    reg on_q = 1'b0;
    initial out_o = 1'b0;
    // when off, flip once so a held result cannot come from the wire
    always @(posedge clk_i) begin
        on_q <= on_i;
        out_o <= on_i ? lvl_i : out_o ^ on_q;
    end
endmodule // dcc_analog_model

/* File: tb/dcc_top_bench.sv */
// Purpose: self-checking bench for dcc_top
// Assumes: 10 MHz clock, sync reset, 100 us settle is 1000 cycles
// Notes: ce and sel held high
`timescale 1ns/10ps
`include "dcc_map.vh"
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module dcc_top_bench;
    reg clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, we = 1'b0;
    reg stop = 1'b0, tick = 1'b0;
    reg [1:0] lvl = 2'h0;
    reg [15:0] adr = 16'h0000;
    reg [7:0] wd = 8'h00, rd;
    wire [7:0] dat;
    wire ack, irq, err;
    wire [1:0] on, cout, cirq;
    int n_errors = 0, n_tests = 0, n_cirq = 0;
    dcc_top i_dcc_top (.clk_i, .rst_i, .ce_i(1'b1), .wb_cyc_i(cyc),
        .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(1'b1),
        .wb_dat_i(wd), .wb_dat_o(dat), .wb_ack_o(ack), .wb_err_o(err),
        .stop_mode_i(stop), .slow_tick_16k_i(tick),
        .channel0_compare_out_i(cout[0]), .channel1_compare_out_i(cout[1]),
        .channel0_on_o(on[0]), .channel1_on_o(on[1]),
        .channel_irq_o(cirq), .irq_o(irq));
    dcc_analog_model i_dcc_analog_model_0 (.clk_i, .on_i(on[0]),
        .lvl_i(lvl[0]), .out_o(cout[0]));
    dcc_analog_model i_dcc_analog_model_1 (.clk_i, .on_i(on[1]),
        .lvl_i(lvl[1]), .out_o(cout[1]));
    initial forever #50 clk_i = ~clk_i;
    // counts request pulses, so a stuck or doubled pulse shows up
    always @(posedge clk_i)
        n_cirq <= n_cirq + int'(cirq[0]) + int'(cirq[1]);
    task report_and_stop; begin
        $display("tests %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    end endtask
    task bus(input [15:0] a, input w, input [7:0] d); int k; begin
        @(posedge clk_i);
        {adr, we, wd, cyc} <= {a, w, d, 1'b1};
        for (k = 0; k < 50 && ack !== 1'b1; k++) @(posedge clk_i);
        if (ack !== 1'b1) begin
            n_errors++;
            report_and_stop;
        end
        rd = dat;
        cyc <= 1'b0;
    end endtask
    task rdc(input [15:0] a, input [7:0] e); begin
        bus(a, 1'b0, 8'h00);
        `CHK(rd, e)
        `CHK(err, 1'b0)
    end endtask
    task tk; begin
        @(posedge clk_i) tick <= 1'b1;
        @(posedge clk_i) tick <= 1'b0;
        repeat (4) @(posedge clk_i);
    end endtask
    task t_regs; int i; begin
        for (i = 0; i < 10; i++) rdc(16'(16'hF950 + i), 8'h00);
        bus(16'hF953, 1'b1, 8'hFF);
        rdc(16'hF953, 8'h00);
        bus(`DCC_CH0_MODE, 1'b1, 8'hFF);
        rdc(`DCC_CH0_MODE, 8'h07);
        $display("done registers");
    end endtask
    task t_edge(input int c); int m; int p; reg [15:0] b; begin
        b = c ? `DCC_CH1_CTRL : `DCC_CH0_CTRL;
        bus(`DCC_IRQ_MASK, 1'b1, 8'h03);
        bus(b + 16'h0001, 1'b1, 8'h00);
        bus(b, 1'b1, 8'h01);
        `CHK(on[c], 1'b1)
        repeat (1000) @(posedge clk_i);
        for (m = 0; m < 4; m++) begin
            bus(b + 16'h0001, 1'b1, m[7:0]);
            bus(`DCC_IRQ_STAT, 1'b1, 8'h03);
            p = n_cirq;
            lvl[c] <= 1'b1;
            repeat (8) @(posedge clk_i);
            `CHK(n_cirq - p, int'(m[1]))
            rdc(b, 8'h03);
            rdc(`DCC_IRQ_STAT, 8'(m[1]) << c);
            `CHK(irq, m[1])
            bus(`DCC_IRQ_STAT, 1'b1, 8'h03);
            p = n_cirq;
            lvl[c] <= 1'b0;
            repeat (8) @(posedge clk_i);
            `CHK(n_cirq - p, int'(m[0]))
            rdc(`DCC_IRQ_STAT, 8'(m[0]) << c);
        end
        bus(`DCC_IRQ_MASK, 1'b1, 8'h00);
        `CHK(irq, 1'b0)
        rdc(b, 8'h01);
        $display("done edges on channel %0d", c);
    end endtask
    task t_hold; begin
        lvl[0] <= 1'b1;
        repeat (8) @(posedge clk_i);
        bus(`DCC_CH0_CTRL, 1'b1, 8'h00);
        lvl[0] <= 1'b0;
        bus(`DCC_IRQ_STAT, 1'b1, 8'h03);
        repeat (8) @(posedge clk_i);
        rdc(`DCC_CH0_CTRL, 8'h02);
        rdc(`DCC_IRQ_STAT, 8'h00);
        $display("done hold");
    end endtask
    task t_samp; begin
        bus(`DCC_CH0_MODE, 1'b1, 8'h06);
        bus(`DCC_CH0_CTRL, 1'b1, 8'h01);
        repeat (1000) @(posedge clk_i);
        tk;
        tk;
        bus(`DCC_IRQ_STAT, 1'b1, 8'h03);
        lvl[0] <= 1'b1;
        repeat (20) @(posedge clk_i);
        rdc(`DCC_IRQ_STAT, 8'h00);
        stop <= 1'b1;
        tk;
        tk;
        rdc(`DCC_IRQ_STAT, 8'h00);
        stop <= 1'b0;
        tk;
        tk;
        rdc(`DCC_IRQ_STAT, 8'h01);
        $display("done sampling");
    end endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_edge(0);
        t_edge(1);
        t_hold;
        t_samp;
        report_and_stop;
    end
endmodule // dcc_top_bench
